/* File: common/sbr_if.sv */
// Purpose: Word-level link between loader and terminal
// Assumes: A strobe marks the first cycle of a 20 us word; contiguous words strobe 1000 cycles apart
// Notes: Manchester coding is not modelled
`timescale 1ns/1ps
`default_nettype none
interface sbr_if;
  logic        bc_stb;   // Loader word start
  logic        bc_cmd;   // Command sync when high, data sync when low
  logic [15:0] bc_word;
  logic        rt_stb;   // Terminal word start
  logic        rt_stat;  // Status sync when high, data sync when low
  logic [15:0] rt_word;

  modport loader   (output bc_stb, bc_cmd, bc_word, input rt_stb, rt_stat, rt_word);
  modport terminal (input bc_stb, bc_cmd, bc_word, output rt_stb, rt_stat, rt_word);
endinterface : sbr_if
`default_nettype wire

/* File: common/sbr_pkg.sv */
// Purpose: Types shared by the loader and terminal ends
// Assumes: Nothing beyond the constants header
// Notes: Word count zero stands for 32 words
`default_nettype none
package sbr_pkg;

  typedef enum logic [2:0] {
    SBR_BC_IDLE, SBR_BC_SPACE, SBR_BC_SEND, SBR_BC_WAIT, SBR_BC_RECV
  } sbr_bc_state_t;

  typedef enum logic [1:0] {
    SBR_RT_IDLE, SBR_RT_RXD, SBR_RT_RESP, SBR_RT_TXD
  } sbr_rt_state_t;

  // Data word count of a command, 1 to 32
  function automatic logic [5:0] sbr_word_count(input logic [4:0] cnt);
    sbr_word_count = (cnt == 5'h00) ? 6'h20 : {1'b0, cnt};
  endfunction : sbr_word_count

endpackage : sbr_pkg
`default_nettype wire

/* File: common/sbr_regs.svh */
// Purpose: Constants for the serial bus reprogram link (loader and terminal ends)
// Assumes: 50 MHz clk_sys; a link word takes 20 us; strobes mark the start of a word
// Notes: Word fields, subaddresses, register offsets and register bits are listed below
`ifndef SBR_REGS_SVH
`define SBR_REGS_SVH

// Timing in microseconds and the clock rate
`define SBR_CLK_MHZ       50
`define SBR_WORD_US       20
`define SBR_RESP_TMO_US   12
`define SBR_RT_RESP_US    4
`define SBR_GAP_US        8
`define SBR_STREAM_US     2000
`define SBR_POLL_US       10000
`define SBR_WORD_CYC      (`SBR_WORD_US * `SBR_CLK_MHZ)
`define SBR_RESP_TMO_CYC  (`SBR_RESP_TMO_US * `SBR_CLK_MHZ)
`define SBR_RT_RESP_CYC   (`SBR_RT_RESP_US * `SBR_CLK_MHZ)
`define SBR_GAP_CYC       (`SBR_GAP_US * `SBR_CLK_MHZ)

// Command and status word fields
`define SBR_W_ADDR_HI     15
`define SBR_W_ADDR_LO     11
`define SBR_W_TR          10
`define SBR_W_ME          10
`define SBR_W_SA_HI       9
`define SBR_W_SA_LO       5
`define SBR_W_CNT_HI      4
`define SBR_W_CNT_LO      0
`define SBR_ST_BUSY       3
`define SBR_DW_BUSY       15

// Subaddresses
`define SBR_SA_ACTIVITY   5'h07
`define SBR_SA_CONFIG     5'h13
`define SBR_SA_REPROG     5'h1d
`define SBR_SA_LOAD       5'h10

// Loader register offsets
`define SBR_REG_CTRL      4'h0
`define SBR_REG_CMD       4'h1
`define SBR_REG_TXD       4'h2
`define SBR_REG_RXD       4'h3
`define SBR_REG_STAT      4'h4
`define SBR_REG_CFG       4'h5
`define SBR_REG_ACT       4'h6

// Control register bits (4:0 hold the terminal address)
`define SBR_CTRL_DBUSY    5
`define SBR_CTRL_RXREP    6
`define SBR_CTRL_VERIFY   7
`define SBR_CTRL_STREAM   8
`define SBR_CTRL_W        9

// Status register bits
`define SBR_STAT_DONE     0
`define SBR_STAT_NORESP   1
`define SBR_STAT_MISM     2
`define SBR_STAT_CFGOK    3
`define SBR_STAT_ACTIVE   4
`define SBR_STAT_POLL     5

`endif

/* File: hdl/sbr_loader.sv */
// Purpose: Loader end: bus controller that runs messages, busy flow control and verify
// Assumes: Software loads TXD words, then writes CMD to start one message
// Notes: Register read data stand one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "sbr_regs.svh"
module sbr_loader import sbr_pkg::*; #(
  parameter int unsigned STREAM_CYC = `SBR_STREAM_US * `SBR_CLK_MHZ,
  parameter int unsigned POLL_CYC   = `SBR_POLL_US * `SBR_CLK_MHZ
)(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Link
  sbr_if.loader            link,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata
);

  sbr_bc_state_t state_r;
  logic [`SBR_CTRL_W-1:0] ctrl_r;
  logic [10:0]   cmd_r;
  logic [15:0]   cfg_ref_r;
  logic [15:0]   act_word_r;
  logic          done_r;
  logic          noresp_r;
  logic          mism_r;
  logic          cfgok_r;
  logic          act_r;
  logic          pend_r;
  logic          poll_r;
  logic          busy_st_r;
  logic          dbusy_r;
  logic [9:0]    tmr_r;
  logic [19:0]   since_r;
  logic [5:0]    widx_r;
  logic [4:0]    txw_idx_r;
  logic [4:0]    rxr_idx_r;
  logic [15:0]   tx_mem [0:31];
  logic [15:0]   rx_mem [0:31];
  logic          go;
  logic [10:0]   msg;
  logic [5:0]    n_data;
  logic [5:0]    n_send;
  logic [19:0]   need;
  logic          msg_end;
  logic          rx_data;
  logic          resp_tmo;
  logic          done_set;

  assign go = reg_wr && reg_addr == `SBR_REG_CMD && state_r == SBR_BC_IDLE;

  // Message in flight: a poll or the user's command
  always_comb begin
    msg    = act_r ? {1'b1, `SBR_SA_ACTIVITY, 5'h01} : cmd_r;
    n_data = sbr_word_count(msg[`SBR_W_CNT_HI:`SBR_W_CNT_LO]);
    n_send = msg[`SBR_W_TR] ? 6'h01 : n_data + 6'h01;
  end

  // Spacing before the next command: gap, stream period or poll period
  always_comb begin
    if (poll_r)
      need = 20'(POLL_CYC);
    else if (ctrl_r[`SBR_CTRL_STREAM] && !act_r)
      need = 20'(STREAM_CYC);
    else
      need = 20'(`SBR_GAP_CYC);
  end

  // Events in the receive phase
  always_comb begin
    msg_end  = state_r == SBR_BC_RECV && !link.rt_stb && tmr_r == 10'(`SBR_WORD_CYC);
    resp_tmo = state_r == SBR_BC_WAIT && !(link.rt_stb && link.rt_stat) && tmr_r == 10'(`SBR_RESP_TMO_CYC);
    // Data after a busy status is dropped
    rx_data  = state_r == SBR_BC_RECV && link.rt_stb && !link.rt_stat && !busy_st_r
               && msg[`SBR_W_TR] && widx_r < n_data;
    done_set = resp_tmo || (msg_end && !busy_st_r && !(act_r && ctrl_r[`SBR_CTRL_DBUSY] && dbusy_r)
               && !(act_r && pend_r));
  end

  // Time since the terminal's last word ended or a response timed out, saturating
  always_ff @(posedge clk_sys) begin
    if (rst)
      since_r <= 20'hfffff;
    else if (msg_end || resp_tmo)
      since_r <= 20'h00000;
    else if (since_r != 20'hfffff)
      since_r <= since_r + 20'h00001;
  end

  // Message sequencer, busy flow control and link drive
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r      <= SBR_BC_IDLE;
      act_r        <= 1'b0;
      pend_r       <= 1'b0;
      poll_r       <= 1'b0;
      busy_st_r    <= 1'b0;
      dbusy_r      <= 1'b0;
      tmr_r        <= 10'h000;
      widx_r       <= 6'h00;
      link.bc_stb  <= 1'b0;
      link.bc_cmd  <= 1'b0;
      link.bc_word <= 16'h0000;
    end else begin
      link.bc_stb <= 1'b0;
      case (state_r)
        SBR_BC_IDLE: begin
          if (go) begin
            act_r   <= ctrl_r[`SBR_CTRL_DBUSY];
            pend_r  <= 1'b1;
            poll_r  <= 1'b0;
            state_r <= SBR_BC_SPACE;
          end
        end
        SBR_BC_SPACE: begin
          if (since_r >= need) begin
            tmr_r   <= 10'h000;
            widx_r  <= 6'h00;
            state_r <= SBR_BC_SEND;
          end
        end
        SBR_BC_SEND: begin
          if (tmr_r == 10'h000) begin
            link.bc_stb  <= 1'b1;
            link.bc_cmd  <= (widx_r == 6'h00);
            link.bc_word <= (widx_r == 6'h00) ? {ctrl_r[4:0], msg} : tx_mem[5'(widx_r - 6'h01)];
          end
          if (tmr_r == 10'(`SBR_WORD_CYC - 1)) begin
            tmr_r  <= 10'h000;
            widx_r <= widx_r + 6'h01;
            if (widx_r + 6'h01 == n_send)
              state_r <= SBR_BC_WAIT;
          end else begin
            tmr_r <= tmr_r + 10'h001;
          end
        end
        SBR_BC_WAIT: begin
          if (link.rt_stb && link.rt_stat) begin
            // Only the busy bit of the status is looked at
            busy_st_r <= link.rt_word[`SBR_ST_BUSY];
            dbusy_r   <= 1'b0;
            tmr_r     <= 10'h000;
            widx_r    <= 6'h00;
            state_r   <= SBR_BC_RECV;
          end else if (resp_tmo) begin
            state_r <= SBR_BC_IDLE;
          end else begin
            tmr_r <= tmr_r + 10'h001;
          end
        end
        SBR_BC_RECV: begin
          if (link.rt_stb) begin
            tmr_r  <= 10'h000;
            widx_r <= widx_r + 6'h01;
            if (act_r && widx_r == 6'h00 && !busy_st_r)
              dbusy_r <= link.rt_word[`SBR_DW_BUSY];
          end else if (msg_end) begin
            tmr_r <= 10'h000;
            if (busy_st_r) begin
              // Busy status: poll until clear, then maybe repeat
              poll_r  <= 1'b1;
              act_r   <= 1'b1;
              if (!act_r)
                pend_r <= cmd_r[`SBR_W_TR] | ctrl_r[`SBR_CTRL_RXREP];
              state_r <= SBR_BC_SPACE;
            end else if (act_r && ctrl_r[`SBR_CTRL_DBUSY] && dbusy_r) begin
              poll_r  <= 1'b1;
              state_r <= SBR_BC_SPACE;
            end else if (act_r && pend_r) begin
              act_r   <= 1'b0;
              poll_r  <= 1'b0;
              state_r <= SBR_BC_SPACE;
            end else begin
              act_r   <= 1'b0;
              pend_r  <= 1'b0;
              poll_r  <= 1'b0;
              state_r <= SBR_BC_IDLE;
            end
          end else begin
            tmr_r <= tmr_r + 10'h001;
          end
        end
        default: state_r <= SBR_BC_IDLE;
      endcase
    end
  end

  // Received data, activity word and configuration match
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      act_word_r <= 16'h0000;
      cfgok_r    <= 1'b0;
    end else if (resp_tmo && !act_r && cmd_r[`SBR_W_SA_HI:`SBR_W_SA_LO] == `SBR_SA_CONFIG) begin
      cfgok_r <= 1'b0;
    end else if (rx_data) begin
      if (act_r) begin
        act_word_r <= link.rt_word;
      end else begin
        rx_mem[widx_r[4:0]] <= link.rt_word;
        if (cmd_r[`SBR_W_SA_HI:`SBR_W_SA_LO] == `SBR_SA_CONFIG && widx_r == 6'h00)
          cfgok_r <= (link.rt_word == cfg_ref_r);
      end
    end
  end

  // Sticky flags: hardware set wins over a software clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_r   <= 1'b0;
      noresp_r <= 1'b0;
      mism_r   <= 1'b0;
    end else begin
      if (done_set)
        done_r <= 1'b1;
      else if (reg_wr && reg_addr == `SBR_REG_STAT && reg_wdata[`SBR_STAT_DONE])
        done_r <= 1'b0;
      if (resp_tmo)
        noresp_r <= 1'b1;
      else if (reg_wr && reg_addr == `SBR_REG_STAT && reg_wdata[`SBR_STAT_NORESP])
        noresp_r <= 1'b0;
      if (rx_data && !act_r && ctrl_r[`SBR_CTRL_VERIFY] && link.rt_word != tx_mem[widx_r[4:0]])
        mism_r <= 1'b1;
      else if (reg_wr && reg_addr == `SBR_REG_STAT && reg_wdata[`SBR_STAT_MISM])
        mism_r <= 1'b0;
    end
  end

  // Register writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_r    <= '0;
      cmd_r     <= 11'h000;
      cfg_ref_r <= 16'h0000;
      txw_idx_r <= 5'h00;
    end else if (reg_wr) begin
      if (reg_addr == `SBR_REG_CTRL) begin
        ctrl_r <= reg_wdata[`SBR_CTRL_W-1:0];
      end else if (go) begin
        cmd_r     <= reg_wdata[10:0];
        txw_idx_r <= 5'h00;
      end else if (reg_addr == `SBR_REG_TXD) begin
        tx_mem[txw_idx_r] <= reg_wdata;
        txw_idx_r         <= txw_idx_r + 5'h01;
      end else if (reg_addr == `SBR_REG_CFG) begin
        cfg_ref_r <= reg_wdata;
      end
    end
  end

  // Register reads, one cycle later; RXD pops the next received word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      rxr_idx_r <= 5'h00;
    end else begin
      if (go)
        rxr_idx_r <= 5'h00;
      else if (reg_rd && reg_addr == `SBR_REG_RXD)
        rxr_idx_r <= rxr_idx_r + 5'h01;
      if (!reg_rd)
        reg_rdata <= 16'h0000;
      else if (reg_addr == `SBR_REG_CTRL)
        reg_rdata <= {{(16-`SBR_CTRL_W){1'b0}}, ctrl_r};
      else if (reg_addr == `SBR_REG_CMD)
        reg_rdata <= {5'h00, cmd_r};
      else if (reg_addr == `SBR_REG_RXD)
        reg_rdata <= rx_mem[rxr_idx_r];
      else if (reg_addr == `SBR_REG_STAT)
        reg_rdata <= {10'h000, poll_r, state_r != SBR_BC_IDLE, cfgok_r, mism_r, noresp_r, done_r};
      else if (reg_addr == `SBR_REG_CFG)
        reg_rdata <= cfg_ref_r;
      else if (reg_addr == `SBR_REG_ACT)
        reg_rdata <= act_word_r;
      else
        reg_rdata <= 16'h0000;
    end
  end

endmodule : sbr_loader
`default_nettype wire

/* File: hdl/sbr_terminal.sv */
// Purpose: Terminal end: answers commands, holds a 32-word image, validates reprogram control
// Assumes: rt_addr, busy inputs and discretes come from logic on clk_sys
// Notes: Busy reported in status bit or, when busy_in_data is high, in activity data bit 15
`timescale 1ns/1ps
`default_nettype none
`include "sbr_regs.svh"
module sbr_terminal import sbr_pkg::*; #(
  parameter logic [15:0] REPROG_KEY = 16'h5a5a
)(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Link
  sbr_if.terminal          link,
  // Unit side
  input  wire logic [4:0]  rt_addr,
  input  wire logic        busy_in,
  input  wire logic        busy_in_data,
  input  wire logic        enable_in,
  input  wire logic [15:0] cfg1,
  input  wire logic [15:0] cfg2,
  output logic             reprog_en,
  output logic             wr_stb,
  output logic [4:0]       wr_idx,
  output logic [15:0]      wr_data
);

  sbr_rt_state_t state_r;
  logic [9:0]    tmr_r;
  logic [5:0]    idx_r;
  logic [5:0]    n_r;
  logic          tr_r;
  logic [4:0]    sa_r;
  logic          undef_r;
  logic          busy_r;
  logic          pend_err_r;
  logic          key_ok_r;
  logic [15:0]   mem [0:31];
  logic          defined;
  logic [15:0]   tx_word;

  // Defined subaddress and direction pairs
  always_comb begin
    if (link.bc_word[`SBR_W_TR])
      defined = link.bc_word[`SBR_W_SA_HI:`SBR_W_SA_LO] inside {`SBR_SA_ACTIVITY, `SBR_SA_CONFIG, `SBR_SA_LOAD};
    else
      defined = link.bc_word[`SBR_W_SA_HI:`SBR_W_SA_LO] inside {`SBR_SA_REPROG, `SBR_SA_LOAD};
  end

  // Outgoing data word for the current transmit message
  always_comb begin
    if (sa_r == `SBR_SA_ACTIVITY)
      tx_word = {busy_in_data & busy_r, 15'h0000};
    else if (sa_r == `SBR_SA_CONFIG)
      tx_word = (idx_r == 6'h00) ? cfg1 : ((idx_r == 6'h01) ? cfg2 : 16'h0000);
    else
      tx_word = mem[idx_r[4:0]];
  end

  // Message sequencer and link drive
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r      <= SBR_RT_IDLE;
      tmr_r        <= 10'h000;
      idx_r        <= 6'h00;
      n_r          <= 6'h00;
      tr_r         <= 1'b0;
      sa_r         <= 5'h00;
      undef_r      <= 1'b0;
      busy_r       <= 1'b0;
      pend_err_r   <= 1'b0;
      key_ok_r     <= 1'b0;
      reprog_en    <= 1'b0;
      wr_stb       <= 1'b0;
      wr_idx       <= 5'h00;
      wr_data      <= 16'h0000;
      link.rt_stb  <= 1'b0;
      link.rt_stat <= 1'b0;
      link.rt_word <= 16'h0000;
    end else begin
      link.rt_stb <= 1'b0;
      wr_stb      <= 1'b0;
      case (state_r)
        SBR_RT_IDLE: begin
          if (link.bc_stb && link.bc_cmd && link.bc_word[`SBR_W_ADDR_HI:`SBR_W_ADDR_LO] == rt_addr) begin
            tr_r     <= link.bc_word[`SBR_W_TR];
            sa_r     <= link.bc_word[`SBR_W_SA_HI:`SBR_W_SA_LO];
            n_r      <= sbr_word_count(link.bc_word[`SBR_W_CNT_HI:`SBR_W_CNT_LO]);
            undef_r  <= ~defined;
            busy_r   <= busy_in;
            key_ok_r <= 1'b0;
            tmr_r    <= 10'h000;
            idx_r    <= 6'h00;
            // Both directions wait for the end of the last incoming word before replying
            state_r  <= SBR_RT_RXD;
          end
        end
        SBR_RT_RXD: begin
          if (link.bc_stb && !link.bc_cmd) begin
            tmr_r <= 10'h000;
            idx_r <= idx_r + 6'h01;
            if (sa_r == `SBR_SA_REPROG && idx_r == 6'h00)
              key_ok_r <= (link.bc_word == REPROG_KEY);
            // Load writes land in the image; erasing is the unit's own business
            if (sa_r == `SBR_SA_LOAD && reprog_en && !busy_r && idx_r < n_r) begin
              mem[idx_r[4:0]] <= link.bc_word;
              wr_stb          <= 1'b1;
              wr_idx          <= idx_r[4:0];
              wr_data         <= link.bc_word;
            end
          end else if (tmr_r == 10'(`SBR_WORD_CYC)) begin
            // Silence: data over; short, long or gapped data is an error
            tmr_r   <= 10'h000;
            state_r <= SBR_RT_RESP;
            if (sa_r == `SBR_SA_REPROG && idx_r == n_r && !undef_r)
              reprog_en <= key_ok_r & enable_in;
          end else begin
            tmr_r <= tmr_r + 10'h001;
          end
        end
        SBR_RT_RESP: begin
          if (tmr_r == 10'(`SBR_RT_RESP_CYC - 1)) begin
            // One status per message, before data or after it
            link.rt_stb  <= 1'b1;
            link.rt_stat <= 1'b1;
            link.rt_word <= {rt_addr, undef_r | pend_err_r, 6'h00,
                             busy_r & ~busy_in_data, 3'h0};
            // Reported once; a receive error shows in the next reply
            pend_err_r   <= ~tr_r & (idx_r != n_r);
            tmr_r        <= 10'h000;
            idx_r        <= 6'h00;
            state_r      <= (tr_r && !undef_r && !(busy_r && !busy_in_data)) ? SBR_RT_TXD : SBR_RT_IDLE;
          end else begin
            tmr_r <= tmr_r + 10'h001;
          end
        end
        SBR_RT_TXD: begin
          if (tmr_r == 10'(`SBR_WORD_CYC - 1)) begin
            link.rt_stb  <= 1'b1;
            link.rt_stat <= 1'b0;
            link.rt_word <= tx_word;
            tmr_r        <= 10'h000;
            idx_r        <= idx_r + 6'h01;
            if (idx_r + 6'h01 == n_r)
              state_r <= SBR_RT_IDLE;
          end else begin
            tmr_r <= tmr_r + 10'h001;
          end
        end
        default: state_r <= SBR_RT_IDLE;
      endcase
    end
  end

endmodule : sbr_terminal
`default_nettype wire

/* File: tb/sbr_link_sva.sv */
// Purpose: Timing and framing checks on the loader-terminal link
// Assumes: Both ends run on clk_sys; word strobes are 1000 cycles apart
// Notes: Counters saturate, so reset looks like a long silence
`timescale 1ns/1ps
`default_nettype none
module sbr_link_sva #(parameter int unsigned POLL_CYC = 500000) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Link
  input wire logic        bc_stb,
  input wire logic        bc_cmd,
  input wire logic [15:0] bc_word,
  input wire logic        rt_stb,
  input wire logic        rt_stat,
  input wire logic [15:0] rt_word
);
  logic [19:0] bc_n_r, rt_n_r;
  logic [4:0]  adr_r;
  logic        seen_r, bsy_r, act_r;
  // Cycles since each side's last word start
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bc_n_r <= '1;
      rt_n_r <= '1;
    end else begin
      bc_n_r <= bc_stb ? 20'h1 : bc_n_r + 20'(~&bc_n_r);
      rt_n_r <= rt_stb ? 20'h1 : rt_n_r + 20'(~&rt_n_r);
    end
  end
  // What the running message asked for and what its status said
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seen_r <= 1'b0;
      bsy_r  <= 1'b0;
      act_r  <= 1'b0;
      adr_r  <= 5'h0;
    end else if (bc_stb && bc_cmd) begin
      seen_r <= 1'b0;
      bsy_r  <= 1'b0;
      act_r  <= bc_word[10:0] == 11'h4e1;
      adr_r  <= bc_word[15:11];
    end else if (rt_stb && rt_stat) begin
      seen_r <= 1'b1;
      bsy_r  <= rt_word[3];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_status; rt_stb && rt_stat; endsequence
  sequence s_cmd; bc_stb && bc_cmd; endsequence
  AST_RESP_WIN: assert property (s_status |-> bc_n_r inside {[20'd1100:20'd1500]})
    else $error("status reply outside its window");
  AST_CMD_GAP: assert property (s_cmd |-> rt_n_r >= 20'd1400)
    else $error("command too close to terminal word");
  AST_STAT_ADR: assert property (s_status |-> rt_word[15:11] == adr_r)
    else $error("status address wrong");
  AST_ONE_STAT: assert property (s_status |-> !seen_r)
    else $error("second status in one message");
  AST_BC_CONTIG: assert property (bc_stb && !bc_cmd |-> bc_n_r == 20'd1000)
    else $error("loader data not contiguous");
  AST_RT_CONTIG: assert property (rt_stb && !rt_stat |-> rt_n_r == 20'd1000)
    else $error("terminal data not contiguous");
  AST_BUSY_NODATA: assert property (rt_stb && !rt_stat |-> !bsy_r)
    else $error("data after busy status");
  AST_BUSY_ACT: assert property ((s_cmd and bsy_r) |-> bc_word[10:0] == 11'h4e1)
    else $error("non-activity command while busy");
  AST_POLL_SPACE: assert property ((s_cmd and (bsy_r && act_r)) |-> bc_n_r >= 20'(POLL_CYC))
    else $error("activity polls too close");
endmodule : sbr_link_sva
`default_nettype wire

/* File: tb/serial_bus_reprogram_protocol_tb_top.sv */
// Purpose: Loader and terminal joined on one link, driven through the register port
// Assumes: Short stream and poll counts
// Notes: Expected words come from the bench's own image queue
`timescale 1ns/1ps
`default_nettype none
`include "sbr_regs.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %0h want %0h", $time, a, e); end end
module serial_bus_reprogram_protocol_tb_top;
  logic        clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, busy_in = 0, busy_in_data = 0, enable_in = 0;
  logic [3:0]  reg_addr = 0;
  logic [4:0]  rt_addr = 0, wr_idx, adr;
  logic [15:0] reg_wdata = 0, reg_rdata, cfg1 = 0, cfg2 = 0, rd, wr_data, img[$], got[$];
  logic        reprog_en, wr_stb;
  int          error_cnt = 0, checks_done = 0, n, m;
  longint      tc[$];
  sbr_if link();
  sbr_loader #(.STREAM_CYC(3000), .POLL_CYC(5000)) u_sbr_loader(.clk_sys, .rst, .link(link), .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  sbr_terminal u_sbr_terminal(.clk_sys, .rst, .link(link), .rt_addr, .busy_in, .busy_in_data, .enable_in,
    .cfg1, .cfg2, .reprog_en, .wr_stb, .wr_idx, .wr_data);
  sbr_link_sva #(.POLL_CYC(5000)) u_sbr_link_sva(.clk_sys, .rst, .bc_stb(link.bc_stb), .bc_cmd(link.bc_cmd),
    .bc_word(link.bc_word), .rt_stb(link.rt_stb), .rt_stat(link.rt_stat), .rt_word(link.rt_word));
  // Clock and monitors of image writes and command starts
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (wr_stb) got.push_back(wr_data);
    if (link.bc_stb && link.bc_cmd) tc.push_back($time);
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rdr
  // One message: start it, wait for done or no-response, check which, clear
  task automatic run(input logic [10:0] c, input logic [1:0] exp);
    int i;
    wr(`SBR_REG_CMD, {5'h0, c});
    rd = 16'h0;
    for (i = 0; i < 30000 && rd[1:0] === 2'h0; i++) rdr(`SBR_REG_STAT);
    if (i == 30000) begin
      error_cnt++;
      $display("unexpected at %0t: message hang", $time);
      end_sim();
    end
    `CHK(rd[1:0], exp)
    wr(`SBR_REG_STAT, 16'h0003);
    rd = 16'h0;
  endtask : run
  // Busy for a number of cycles from the next edge
  task automatic busy_for(input int c, input logic dat);
    @(posedge clk_sys);
    busy_in      <= 1'b1;
    busy_in_data <= dat;
    fork
      begin
        repeat (c) @(posedge clk_sys);
        busy_in <= 1'b0;
      end
    join_none
  endtask : busy_for
  task automatic load(input logic [15:0] ctl);
    img.delete();
    got.delete();
    n = $urandom_range(4, 2);
    wr(`SBR_REG_CTRL, ctl | adr);
    for (int k = 0; k < n; k++) begin
      img.push_back(16'($urandom));
      wr(`SBR_REG_TXD, img[k]);
    end
  endtask : load
  task automatic cfg_read();
    run({1'b1, 5'h13, 5'h02}, 2'h1);
    rdr(`SBR_REG_RXD);
    `CHK(rd, cfg1)
    rdr(`SBR_REG_RXD);
    `CHK(rd, cfg2)
  endtask : cfg_read
  initial begin
    rd = 16'h0;
    void'($urandom(6));
    adr = 5'($urandom_range(30, 1));
    @(posedge clk_sys);
    rt_addr <= adr;
    cfg1    <= 16'($urandom);
    cfg2    <= 16'($urandom);
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset state and an unmapped address
    rdr(`SBR_REG_STAT);
    `CHK(rd, 16'h0)
    rdr(4'hf);
    `CHK(rd, 16'h0)
    // Configuration read matches, then a silent address clears the match
    wr(`SBR_REG_CTRL, {11'h0, adr});
    wr(`SBR_REG_CFG, cfg1);
    cfg_read();
    rdr(`SBR_REG_STAT);
    `CHK(rd[3], 1'b1)
    wr(`SBR_REG_CTRL, {11'h0, adr ^ 5'h1f});
    run({1'b1, 5'h13, 5'h02}, 2'h3);
    rdr(`SBR_REG_STAT);
    `CHK(rd[3], 1'b0)
    $display("config test done");
    // Reprogram enable, load, then read back
    wr(`SBR_REG_CTRL, {11'h0, adr});
    enable_in <= 1'b1;
    wr(`SBR_REG_TXD, 16'h5a5a);
    run({1'b0, 5'h1d, 5'h01}, 2'h1);
    `CHK(reprog_en, 1'b1)
    load(16'h0000);
    run({1'b0, 5'h10, 5'(n)}, 2'h1);
    `CHK(got.size(), n)
    for (int k = 0; k < n; k++) `CHK(got[k], img[k])
    wr(`SBR_REG_CTRL, 16'h0080 | adr);
    run({1'b1, 5'h10, 5'(n)}, 2'h1);
    for (int k = 0; k < n; k++) begin
      rdr(`SBR_REG_RXD);
      `CHK(rd, img[k])
    end
    rdr(`SBR_REG_STAT);
    `CHK(rd[2], 1'b0)
    // A wrong expected word in TXD must show as a verify mismatch
    wr(`SBR_REG_TXD, ~img[0]);
    run({1'b1, 5'h10, 5'(n)}, 2'h1);
    rdr(`SBR_REG_STAT);
    `CHK(rd[2], 1'b1)
    wr(`SBR_REG_STAT, 16'h0004);
    $display("load test done");
    // Busy on a transmit: polls, then the transmit again
    wr(`SBR_REG_CTRL, {11'h0, adr});
    m = tc.size();
    busy_for(8000, 1'b0);
    cfg_read();
    `CHK(tc.size() - m >= 3, 1'b1)
    // Busy on a receive with repeat chosen: words land once
    load(16'h0040);
    busy_for(8000, 1'b0);
    run({1'b0, 5'h10, 5'(n)}, 2'h1);
    `CHK(got.size(), n)
    $display("busy test done");
    // Stream spacing between two identical messages
    wr(`SBR_REG_CTRL, 16'h0100 | adr);
    cfg_read();
    cfg_read();
    `CHK(tc[$] - tc[$-1] >= 64'd144000, 1'b1)
    // Busy seen only in the activity data word
    wr(`SBR_REG_CTRL, 16'h0020 | adr);
    busy_for(8000, 1'b1);
    cfg_read();
    rdr(`SBR_REG_ACT);
    `CHK(rd[15], 1'b0)
    $display("stream and data busy tests done");
    end_sim();
  end
endmodule : serial_bus_reprogram_protocol_tb_top
`default_nettype wire
